// file: tpe_map.svh
// register offsets, field positions and timing counts of the timer block
`ifndef TPE_MAP_SVH
`define TPE_MAP_SVH
// ****************************************************************
// register offsets (byte addresses on the plain port)
// ****************************************************************
`define TPE_ADDR_W          8
`define TPE_OFF_RUN         8'h00
`define TPE_OFF_MODE        8'h04
`define TPE_OFF_CLK         8'h08
`define TPE_OFF_FFCTL       8'h0c
`define TPE_OFF_CMP_A       8'h10
`define TPE_OFF_CMP_B       8'h14
`define TPE_OFF_CMP_C       8'h18
`define TPE_OFF_CMP_D       8'h1c
`define TPE_OFF_IRQ_EN      8'h20
`define TPE_OFF_IRQ_STAT    8'h24
`define TPE_OFF_CNT_STAT    8'h28
// ****************************************************************
// field positions
// ****************************************************************
`define TPE_RUN_A           0
`define TPE_RUN_B           1
`define TPE_RUN_C           2
`define TPE_RUN_D           3
`define TPE_RUN_PRE         7
`define TPE_MODE_PWM        2
`define TPE_MODE_SINE       3
`define TPE_MODE_CASC       4
`define TPE_FF_CAP_C        6
`define TPE_FF_CAP_D        7
`define TPE_FF_INIT         0
`define TPE_FF_SET          1
`define TPE_IRQ_A           0
`define TPE_IRQ_B           1
`define TPE_IRQ_C           2
`define TPE_IRQ_D           3
// ****************************************************************
// reset values
// ****************************************************************
`define TPE_RST_FFCTL       8'hc0
// ****************************************************************
// prescaler taps: divide by 8, 128, 2048 of the system clock
// ****************************************************************
`define TPE_PRE_W           11
`define TPE_TAP_8           2
`define TPE_TAP_128         6
`define TPE_TAP_2048        10
`endif

// file: tpe_pkg.sv
// types shared by the timer block
`default_nettype none
`include "tpe_map.svh"
package tpe_pkg;
    typedef logic [7:0] tpe_byte_t;
    typedef logic [`TPE_ADDR_W-1:0] tpe_addr_t;
    typedef enum logic [1:0] {
        TPE_OVF_RSV,
        TPE_OVF_6,
        TPE_OVF_7,
        TPE_OVF_8
    } tpe_ovf_e;
endpackage : tpe_pkg
`default_nettype wire

// file: tpe_timer.sv
// four 8-bit timers with pwm, event counter, cascade and counter latch
//
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "tpe_map.svh"

module tpe_timer (
    input  wire logic               sys_clk_i,
    input  wire logic               rst_i,
    input  wire tpe_pkg::tpe_addr_t addr_i,
    input  wire tpe_pkg::tpe_byte_t wdata_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    input  wire logic               external_count_in_i,
    output logic [7:0]              rdata_o,
    output logic                    timer_wave_out_o,
    output logic                    irq_o
);
    import tpe_pkg::*;

    // ****************************************************************
    // registers
    // ****************************************************************
    tpe_byte_t timer_run_reg, next_timer_run_reg;
    tpe_byte_t timer_mode_reg, next_timer_mode_reg;
    tpe_byte_t timer_clock_select_reg, next_timer_clock_select_reg;
    tpe_byte_t flipflop_control_reg, next_flipflop_control_reg;
    tpe_byte_t compare_reg_a, next_compare_reg_a;
    tpe_byte_t compare_reg_b, next_compare_reg_b;
    tpe_byte_t compare_reg_c, next_compare_reg_c;
    tpe_byte_t compare_reg_d, next_compare_reg_d;
    tpe_byte_t latch_c, next_latch_c;
    tpe_byte_t latch_d, next_latch_d;
    logic      latched_c, next_latched_c;
    logic      latched_d, next_latched_d;
    logic [3:0] irq_enable_reg, next_irq_enable_reg;
    logic [3:0] irq_stat, next_irq_stat;
    tpe_byte_t rdata, next_rdata;
    logic      irq, next_irq;

    // ****************************************************************
    // counters
    // ****************************************************************
    logic [`TPE_PRE_W-1:0] pre, next_pre;
    logic [`TPE_PRE_W-1:0] pre_d;
    tpe_byte_t cnt [4];
    tpe_byte_t next_cnt [4];
    logic      wave, next_wave;
    logic      ext_d, next_ext_d;
    logic      ext_lvl, next_ext_lvl;
    logic [3:0] tick;
    logic [3:0] match;
    logic [3:0] clr;
    logic       ext_rise;
    logic       pwm_mode;
    logic       pwm_top;
    tpe_byte_t  pwm_max;

    // tap select: code 01/10/11 picks /8, /128, /2048; 00 is special
    function automatic logic tap_edge(input logic [1:0] sel,
                                      input logic [`TPE_PRE_W-1:0] p,
                                      input logic [`TPE_PRE_W-1:0] pd);
        logic r;
        r = 1'b0;
        unique case (sel)
            2'b00: r = 1'b0;
            2'b01: r = p[`TPE_TAP_8] & ~pd[`TPE_TAP_8];
            2'b10: r = p[`TPE_TAP_128] & ~pd[`TPE_TAP_128];
            2'b11: r = p[`TPE_TAP_2048] & ~pd[`TPE_TAP_2048];
        endcase
        return r;
    endfunction : tap_edge

    function automatic logic hit(input tpe_addr_t a, input tpe_addr_t off);
        return a == off;
    endfunction : hit

    assign pwm_mode = timer_mode_reg[`TPE_MODE_PWM];
    // overflow code 00 is reserved and runs as n = 8
    always_comb begin
        unique case (tpe_ovf_e'(timer_mode_reg[1:0]))
            TPE_OVF_6: pwm_max = 8'h3f;
            TPE_OVF_7: pwm_max = 8'h7f;
            default:   pwm_max = 8'hff;
        endcase
    end

    // the external pin is taken as synchronous; the sine option samples
    // the zero-cross comparator result, which arrives as the same pin
    // level, so both settings share one rising-edge detector here
    assign ext_rise = ext_lvl & ~ext_d;

    always_comb begin
        next_ext_d   = ext_lvl;
        next_ext_lvl = external_count_in_i;
        pre_d        = pre - 11'h001;
        next_pre     = timer_run_reg[`TPE_RUN_PRE] ? pre + 11'h001 : pre;
    end

    // ****************************************************************
    // tick generation and match per timer
    // ****************************************************************
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_tick
            logic [1:0] sel;
            assign sel = timer_clock_select_reg[2*g+1:2*g];
            if (g == 2) begin : g_ev
                // clock source 00 turns the third timer into a counter
                assign tick[g] = timer_run_reg[g]
                    & timer_run_reg[`TPE_RUN_PRE]
                    & ((sel == 2'b00) ? ext_rise
                                      : tap_edge(sel, pre, pre_d));
            end else if (g == 3) begin : g_casc
                assign tick[g] = timer_run_reg[g]
                    & (timer_mode_reg[`TPE_MODE_CASC]
                    ? (tick[2] & (cnt[2] == 8'hff))
                    : (timer_run_reg[`TPE_RUN_PRE]
                       & tap_edge(sel, pre, pre_d)));
            end else begin : g_pl
                assign tick[g] = timer_run_reg[g]
                    & timer_run_reg[`TPE_RUN_PRE]
                    & tap_edge(sel, pre, pre_d);
            end
        end
    endgenerate

    assign match[0] = tick[0] & (cnt[0] + 8'h01 == compare_reg_a);
    assign match[1] = tick[1] & (cnt[1] + 8'h01 == compare_reg_b);
    assign match[2] = tick[2] & (cnt[2] + 8'h01 == compare_reg_c);
    assign match[3] = tick[3] & (cnt[3] + 8'h01 == compare_reg_d);
    assign pwm_top  = tick[1] & (cnt[1] + 8'h01 == pwm_max);
    assign clr[0]   = match[0];
    assign clr[1]   = pwm_mode ? pwm_top : match[1];
    // in cascade mode the third and fourth counters run free so a latch sees a true count
    assign clr[2]   = match[2] & ~timer_mode_reg[`TPE_MODE_CASC];
    assign clr[3]   = match[3] & ~timer_mode_reg[`TPE_MODE_CASC];

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!timer_run_reg[i])
                next_cnt[i] = 8'h00;
            else if (clr[i])
                next_cnt[i] = 8'h00;
            else if (tick[i])
                next_cnt[i] = cnt[i] + 8'h01;
            else
                next_cnt[i] = cnt[i];
        end
    end

    // ****************************************************************
    // wave output flip-flop
    // ****************************************************************
    always_comb begin
        next_wave = wave;
        if (wr_i && hit(addr_i, `TPE_OFF_FFCTL) && wdata_i[`TPE_FF_INIT])
            next_wave = wdata_i[`TPE_FF_SET];
        else if (pwm_mode)
            next_wave = wave ^ match[1] ^ pwm_top;
        else
            next_wave = wave ^ match[1];
    end

    // ****************************************************************
    // register bus
    // ****************************************************************
    always_comb begin
        next_timer_run_reg          = timer_run_reg;
        next_timer_mode_reg         = timer_mode_reg;
        next_timer_clock_select_reg = timer_clock_select_reg;
        next_flipflop_control_reg   = flipflop_control_reg;
        next_compare_reg_a          = compare_reg_a;
        next_compare_reg_b          = compare_reg_b;
        next_compare_reg_c          = compare_reg_c;
        next_compare_reg_d          = compare_reg_d;
        next_irq_enable_reg         = irq_enable_reg;
        next_latch_c                = latch_c;
        next_latch_d                = latch_d;
        next_latched_c              = latched_c;
        next_latched_d              = latched_d;
        next_irq_stat               = irq_stat;
        if (wr_i) begin
            unique case (1'b1)
                hit(addr_i, `TPE_OFF_RUN):   next_timer_run_reg = wdata_i;
                hit(addr_i, `TPE_OFF_MODE):  next_timer_mode_reg = wdata_i;
                hit(addr_i, `TPE_OFF_CLK):
                    next_timer_clock_select_reg = wdata_i;
                hit(addr_i, `TPE_OFF_FFCTL): begin
                    next_flipflop_control_reg = wdata_i;
                    if (!wdata_i[`TPE_FF_CAP_C]) begin
                        next_latch_c   = cnt[2];
                        next_latched_c = 1'b1;
                    end
                    if (!wdata_i[`TPE_FF_CAP_D]) begin
                        next_latch_d   = cnt[3];
                        next_latched_d = 1'b1;
                    end
                end
                hit(addr_i, `TPE_OFF_CMP_A): next_compare_reg_a = wdata_i;
                hit(addr_i, `TPE_OFF_CMP_B): next_compare_reg_b = wdata_i;
                hit(addr_i, `TPE_OFF_CMP_C): begin
                    next_compare_reg_c = wdata_i;
                    next_latched_c     = 1'b0;
                end
                hit(addr_i, `TPE_OFF_CMP_D): begin
                    next_compare_reg_d = wdata_i;
                    next_latched_d     = 1'b0;
                end
                hit(addr_i, `TPE_OFF_IRQ_EN):
                    next_irq_enable_reg = wdata_i[3:0];
                hit(addr_i, `TPE_OFF_IRQ_STAT):
                    next_irq_stat = irq_stat & ~wdata_i[3:0];
                default: ;
            endcase
        end
        // set wins over a same-cycle clear
        next_irq_stat = next_irq_stat | match;
        next_irq      = |(next_irq_stat & next_irq_enable_reg);
    end

    always_comb begin
        next_rdata = 8'h00;
        if (rd_i) begin
            unique case (1'b1)
                hit(addr_i, `TPE_OFF_RUN):      next_rdata = timer_run_reg;
                hit(addr_i, `TPE_OFF_MODE):     next_rdata = timer_mode_reg;
                hit(addr_i, `TPE_OFF_CLK):
                    next_rdata = timer_clock_select_reg;
                // compare values are write-only; only a latched count returns
                hit(addr_i, `TPE_OFF_CMP_C):
                    next_rdata = latched_c ? latch_c : 8'h00;
                hit(addr_i, `TPE_OFF_CMP_D):
                    next_rdata = latched_d ? latch_d : 8'h00;
                hit(addr_i, `TPE_OFF_IRQ_EN):
                    next_rdata = {4'h0, irq_enable_reg};
                hit(addr_i, `TPE_OFF_IRQ_STAT): next_rdata = {4'h0, irq_stat};
                hit(addr_i, `TPE_OFF_CNT_STAT): next_rdata = cnt[1];
                default:                        next_rdata = 8'h00;
            endcase
        end
    end

    // ****************************************************************
    // state registers
    // ****************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            timer_run_reg          <= 8'h00;
            timer_mode_reg         <= 8'h00;
            timer_clock_select_reg <= 8'h00;
            flipflop_control_reg   <= `TPE_RST_FFCTL;
            compare_reg_a          <= 8'h00;
            compare_reg_b          <= 8'h00;
            compare_reg_c          <= 8'h00;
            compare_reg_d          <= 8'h00;
            latch_c                <= 8'h00;
            latch_d                <= 8'h00;
            latched_c              <= 1'b0;
            latched_d              <= 1'b0;
            irq_enable_reg         <= 4'h0;
            irq_stat               <= 4'h0;
            rdata                  <= 8'h00;
            irq                    <= 1'b0;
            pre                    <= 11'h000;
            wave                   <= 1'b0;
            ext_d                  <= 1'b0;
            ext_lvl                <= 1'b0;
            for (int i = 0; i < 4; i++) cnt[i] <= 8'h00;
        end else begin
            timer_run_reg          <= next_timer_run_reg;
            timer_mode_reg         <= next_timer_mode_reg;
            timer_clock_select_reg <= next_timer_clock_select_reg;
            flipflop_control_reg   <= next_flipflop_control_reg;
            compare_reg_a          <= next_compare_reg_a;
            compare_reg_b          <= next_compare_reg_b;
            compare_reg_c          <= next_compare_reg_c;
            compare_reg_d          <= next_compare_reg_d;
            latch_c                <= next_latch_c;
            latch_d                <= next_latch_d;
            latched_c              <= next_latched_c;
            latched_d              <= next_latched_d;
            irq_enable_reg         <= next_irq_enable_reg;
            irq_stat               <= next_irq_stat;
            rdata                  <= next_rdata;
            irq                    <= next_irq;
            pre                    <= next_pre;
            wave                   <= next_wave;
            ext_d                  <= next_ext_d;
            ext_lvl                <= next_ext_lvl;
            for (int i = 0; i < 4; i++) cnt[i] <= next_cnt[i];
        end
    end

    assign rdata_o          = rdata;
    assign timer_wave_out_o = wave;
    assign irq_o            = irq;
endmodule : tpe_timer
`default_nettype wire

// file: tpe_timer_monitor.sv
// port-level assertion checker for the timer block
`timescale 1ns/10ps
`default_nettype none
`include "tpe_map.svh"
module tpe_timer_monitor (
    input wire logic               sys_clk_i,
    input wire logic               rst_i,
    input wire tpe_pkg::tpe_addr_t addr_i,
    input wire tpe_pkg::tpe_byte_t wdata_i,
    input wire logic               wr_i,
    input wire logic               rd_i,
    input wire logic               external_count_in_i,
    input wire logic [7:0]         rdata_o,
    input wire logic               timer_wave_out_o,
    input wire logic               irq_o
);
    import tpe_pkg::*;
    // shadow of the enable mask: one piece of state rebuildable from the ports
    logic [3:0] en_q;
    logic [3:0] next_en_q;
    always_comb begin
        next_en_q = en_q;
        if (wr_i && addr_i == `TPE_OFF_IRQ_EN) begin
            next_en_q = wdata_i[3:0];
        end
    end
    always_ff @(posedge sys_clk_i) begin
        en_q <= rst_i ? 4'h0 : next_en_q;
    end
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    // ****************************************************************
    // assertions
    // ****************************************************************
    rd_idle_zero_a: assert property (!$past(rd_i) |-> rdata_o == 8'h00)
        else $error("read data not zero outside a read");
    cmp_hidden_a: assert property (
        rd_i && (addr_i == `TPE_OFF_CMP_A || addr_i == `TPE_OFF_CMP_B)
        |=> rdata_o == 8'h00) else $error("compare value read back");
    unmapped_zero_a: assert property (
        rd_i && addr_i > `TPE_OFF_CNT_STAT |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");
    en_readback_a: assert property (
        rd_i && addr_i == `TPE_OFF_IRQ_EN |=> rdata_o[3:0] == en_q)
        else $error("enable mask read back wrong");
    irq_masked_a: assert property (
        irq_o |-> (en_q != 4'h0 || $past(en_q) != 4'h0))
        else $error("interrupt high with all sources masked");
    irq_sticky_a: assert property (
        irq_o && !wr_i && !$past(wr_i) |=> irq_o)
        else $error("interrupt dropped without a write");
    irq_fall_a: assert property (
        $fell(irq_o) |-> ($past(wr_i) || $past(wr_i, 2)))
        else $error("interrupt fell with no write before it");
    wave_load_a: assert property (
        wr_i && addr_i == `TPE_OFF_FFCTL && wdata_i[0]
        |=> timer_wave_out_o == $past(wdata_i[1]))
        else $error("wave output not loaded by software");
    irq_seen_c: cover property ($rose(irq_o));
    wave_seen_c: cover property ($rose(timer_wave_out_o));
    latch_seen_c: cover property (
        rd_i && addr_i == `TPE_OFF_CMP_C ##1 rdata_o != 8'h00);
endmodule : tpe_timer_monitor
bind tpe_timer tpe_timer_monitor u_tpe_timer_monitor (
    .sys_clk_i           (sys_clk_i),
    .rst_i               (rst_i),
    .addr_i              (addr_i),
    .wdata_i             (wdata_i),
    .wr_i                (wr_i),
    .rd_i                (rd_i),
    .external_count_in_i (external_count_in_i),
    .rdata_o             (rdata_o),
    .timer_wave_out_o    (timer_wave_out_o),
    .irq_o               (irq_o)
);
`default_nettype wire

// file: tb_tpe_timer.sv
// self-checking testbench of the timer block
`timescale 1ns/10ps
`default_nettype none
`include "tpe_map.svh"
module tb_tpe_timer;
    import tpe_pkg::*;
    logic      sys_clk;
    logic      rst;
    tpe_addr_t addr;
    tpe_byte_t wdata;
    logic      wr;
    logic      rd;
    logic      ext;
    tpe_byte_t rdata;
    logic      wave;
    logic      irq;
    int        error_cnt;
    int        cmp_count;
    tpe_timer u_tpe_timer (.sys_clk_i(sys_clk), .rst_i(rst), .addr_i(addr),
        .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .external_count_in_i(ext),
        .rdata_o(rdata), .timer_wave_out_o(wave), .irq_o(irq));
    always #2 sys_clk = ~sys_clk;
    // ****************************************************************
    // shared tasks
    // ****************************************************************
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic test_done;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    task automatic do_reset(input int n);
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (n) @(posedge sys_clk);
        rst <= 1'b0;
    endtask : do_reset
    task automatic wr_reg(input tpe_byte_t a, input tpe_byte_t d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask : wr_reg
    task automatic rd_chk(input tpe_byte_t a, input tpe_byte_t m,
                          input tpe_byte_t exp);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        chk({8'h00, rdata & m}, {8'h00, exp});
    endtask : rd_chk
    // bounded wait; counts edges until the watched output reaches val
    task automatic wait_sig(input bit sel, input logic val, input int lim,
                            output int n);
        n = 0;
        do begin
            @(posedge sys_clk);
            #1;
            n++;
        end while ((sel ? irq : wave) !== val && n < lim);
        if ((sel ? irq : wave) !== val) begin
            error_cnt++;
            test_done();
        end
    endtask : wait_sig
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            ext <= 1'b1;
            repeat (2) @(posedge sys_clk);
            ext <= 1'b0;
            repeat (2) @(posedge sys_clk);
        end
    endtask : pulse
    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic pwm_run(input logic [1:0] ovf, input tpe_byte_t sel,
                           input int div);
        int top, lo, t0, t1, t2;
        // overflow codes 01/10/11 give n = 6/7/8; reserved 00 runs as 8
        top = (1 << ((ovf == 2'b00) ? 8 : 5 + ovf)) - 1;
        lo = (top - 45 < 45) ? top - 45 : 45;
        do_reset(2);
        wr_reg(`TPE_OFF_RUN, 8'h80);
        wr_reg(`TPE_OFF_CLK, sel);
        wr_reg(`TPE_OFF_MODE, {6'h01, ovf});
        wr_reg(`TPE_OFF_CMP_B, 8'h2d);
        wr_reg(`TPE_OFF_FFCTL, 8'hc1);
        wr_reg(`TPE_OFF_RUN, 8'h82);
        wait_sig(1'b0, 1'b1, 3 * top * div, t0);
        wait_sig(1'b0, 1'b0, 2 * top * div, t1);
        wait_sig(1'b0, 1'b1, 2 * top * div, t2);
        chk(16'(t1 + t2), 16'(top * div));
        chk(16'((t1 < t2) ? t1 : t2), 16'(lo * div));
    endtask : pwm_run
    task automatic irq_pwm;
        int n;
        do_reset(2);
        wr_reg(`TPE_OFF_RUN, 8'h80);
        wr_reg(`TPE_OFF_CLK, 8'h05);
        wr_reg(`TPE_OFF_MODE, 8'h05);
        wr_reg(`TPE_OFF_CMP_A, 8'h0a);
        wr_reg(`TPE_OFF_CMP_B, 8'h2d);
        wr_reg(`TPE_OFF_IRQ_EN, 8'h03);
        wr_reg(`TPE_OFF_RUN, 8'h83);
        wait_sig(1'b1, 1'b1, 200, n);
        rd_chk(`TPE_OFF_IRQ_STAT, 8'h03, 8'h01);
        // compare values are kept here, since the block never returns them
        wr_reg(`TPE_OFF_CMP_A, 8'h08);
        wr_reg(`TPE_OFF_IRQ_EN, 8'h02);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({15'h0, irq}, 16'h0);
        wait_sig(1'b1, 1'b1, 600, n);
        rd_chk(`TPE_OFF_IRQ_STAT, 8'h02, 8'h02);
        wr_reg(`TPE_OFF_CMP_A, 8'h0c);
        wr_reg(`TPE_OFF_IRQ_STAT, 8'h0f);
        repeat (3) @(posedge sys_clk);
        #1;
        chk({15'h0, irq}, 16'h0);
        // pulse width change from the handler: halt, rewrite, force high
        wr_reg(`TPE_OFF_RUN, 8'h81);
        wr_reg(`TPE_OFF_CMP_B, 8'h10);
        wr_reg(`TPE_OFF_FFCTL, 8'hc3);
        @(posedge sys_clk);
        #1;
        chk({15'h0, wave}, 16'h1);
        wr_reg(`TPE_OFF_RUN, 8'h83);
    endtask : irq_pwm
    task automatic event_count;
        int n;
        do_reset(2);
        wr_reg(`TPE_OFF_CLK, 8'h00);
        wr_reg(`TPE_OFF_CMP_C, 8'h05);
        wr_reg(`TPE_OFF_IRQ_EN, 8'h04);
        wr_reg(`TPE_OFF_RUN, 8'h84);
        pulse(3);
        repeat (4) @(posedge sys_clk);
        wr_reg(`TPE_OFF_FFCTL, 8'h80);
        rd_chk(`TPE_OFF_CMP_C, 8'hff, 8'h03);
        chk({15'h0, irq}, 16'h0);
        pulse(2);
        wait_sig(1'b1, 1'b1, 10, n);
        rd_chk(`TPE_OFF_IRQ_STAT, 8'h04, 8'h04);
    endtask : event_count
    task automatic cascade;
        do_reset(2);
        wr_reg(`TPE_OFF_MODE, 8'h18);
        wr_reg(`TPE_OFF_RUN, 8'h8c);
        pulse(258);
        repeat (4) @(posedge sys_clk);
        wr_reg(`TPE_OFF_FFCTL, 8'h00);
        rd_chk(`TPE_OFF_CMP_C, 8'hff, 8'h02);
        rd_chk(`TPE_OFF_CMP_D, 8'hff, 8'h01);
    endtask : cascade
    task automatic reg_map;
        wr_reg(`TPE_OFF_CMP_A, 8'h55);
        rd_chk(`TPE_OFF_CMP_A, 8'hff, 8'h00);
        wr_reg(`TPE_OFF_CMP_B, 8'h2d);
        rd_chk(`TPE_OFF_CMP_B, 8'hff, 8'h00);
        wr_reg(8'h30, 8'haa);
        rd_chk(8'h30, 8'hff, 8'h00);
        wr_reg(`TPE_OFF_IRQ_EN, 8'h0a);
        rd_chk(`TPE_OFF_IRQ_EN, 8'h0f, 8'h0a);
    endtask : reg_map
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        addr = '0;
        wdata = '0;
        wr = 1'b0;
        rd = 1'b0;
        ext = 1'b0;
        error_cnt = 0;
        cmp_count = 0;
        do_reset(20);
        reg_map();
        for (int i = 0; i < 4; i++) begin
            pwm_run(2'(i), 8'h04, 8);
        end
        pwm_run(2'b01, 8'h08, 128);
        irq_pwm();
        event_count();
        cascade();
        test_done();
    end
endmodule : tb_tpe_timer
`default_nettype wire
